/* File: common/i2c_target_defs.svh */
`ifndef I2C_TARGET_DEFS_SVH
`define I2C_TARGET_DEFS_SVH
// Register byte addresses
`define OFS_CONTROL_A 4'h0
`define OFS_STATUS 4'h4
`define OFS_INT_FLAG 4'h8
`define OFS_INT_MASK 4'hc
`define OFS_OWN_ADDR 4'h0
`define OFS_COMMAND 4'h4
// Control field positions
`define CA_ENABLE 1
`define CA_MODE_HI 4
`define CA_MODE_LO 2
`define CA_STBY_RUN 7
`define CA_PIN_USAGE 16
`define CA_HOLD_HI 21
`define CA_HOLD_LO 20
`define CA_TO_EN 23
`define CA_SPEED_HI 25
`define CA_SPEED_LO 24
// Writable control bits
`define CA_WMASK 32'h03b1_009e
`define CA_RESET 32'h0000_0000
// Target mode code
`define MODE_TARGET 3'h4
// Interrupt flag positions
`define IF_ADDR 0
`define IF_STOP 1
`define IF_TMO 2
`define IF_SYNC 3
// Timing
`define CLK_NS 40
`define CLK_HZ 25000000
`define TMO_MS 25
`define HOLD1_NS 50
`define HOLD2_NS 300
`define HOLD3_NS 400
`define BITS_PER_BYTE 4'h8
`endif

/* File: common/i2c_target_pkg.sv */
package i2c_target_pkg;
   // Engine states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ADDR = 5'b00010,
      ST_ACK = 5'b00100,
      ST_HOLD = 5'b01000,
      ST_PASS = 5'b10000
   } state_type;
   // Control register fields
   typedef struct packed {
      logic [5:0] rsv_hi;
      logic [1:0] speed_class;
      logic clock_low_ext_timeout_en;
      logic rsv_22;
      logic [1:0] data_hold_select;
      logic [2:0] rsv_19_17;
      logic pin_usage_select;
      logic [7:0] rsv_15_8;
      logic standby_run;
      logic [1:0] rsv_6_5;
      logic [2:0] mode;
      logic enable;
      logic rsv_0;
   } control_type;
   // Sampled link levels
   typedef struct packed {
      logic scl;
      logic sda;
   } link_type;
endpackage : i2c_target_pkg

/* File: src/i2c_target_control.sv */
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`include "i2c_target_defs.svh"
// Overview of operation
// [R1] Software writes mode 0x04 for target
// [R2] Cumulative low over 25ms releases, resets
// [R3] Timeout keeps already set flags
// [R4] Addressed target flags stop after timeout
// [R5] Hold select delays data after falling clock
// [R6] Pin usage bit selects four-wire
// [R7] Standby drops reception or wakes
// [R8] Speed class field selects bus mode
// [R9] Enable delayed, reads back at once
// [R10] Other settings act without synchronization
// [R11] Busy shown while enable crosses
module i2c_target_control #(
   parameter int TIMEOUT_CYCLES = `TMO_MS * (`CLK_HZ / 1000)
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic standby_sleep,
   output logic wake_req,
   output logic irq,
   output logic four_wire_en,
   output logic [1:0] speed_class
);
   // Hold counts, least time rounded up
   localparam logic [3:0] HOLD1 = 4'((`HOLD1_NS + `CLK_NS - 1) / `CLK_NS);
   localparam logic [3:0] HOLD2 = 4'((`HOLD2_NS + `CLK_NS - 1) / `CLK_NS);
   localparam logic [3:0] HOLD3 = 4'((`HOLD3_NS + `CLK_NS - 1) / `CLK_NS);
   localparam logic [19:0] TMO_LIMIT = 20'(TIMEOUT_CYCLES);

   i2c_target_pkg::control_type ctrl_r, ctrl_nxt; // Control word
   logic [3:0] flag_r, flag_nxt;    // Sticky interrupt flags
   logic [3:0] mask_r, mask_nxt;    // Interrupt mask
   logic [6:0] own_r, own_nxt;      // Own bus address
   logic ack_r, ack_nxt;            // Bus answer phase
   logic [31:0] rdata_r, rdata_nxt; // Registered read data
   logic [1:0] ensync_r, ensync_nxt; // Enable crossing stages
   logic release_req;               // Software clock release
   logic [3:0] ev;                  // Events this cycle
   logic busy;                      // Enable crossing busy
   logic active;                    // Target running

   // Link sampling chains
   logic [2:0] scl_sh_r, scl_sh_nxt;
   logic [2:0] sda_sh_r, sda_sh_nxt;
   i2c_target_pkg::link_type lvl_r, lvl_nxt; // Filtered levels
   i2c_target_pkg::link_type prv_r, prv_nxt; // Levels one cycle back

   // Engine state
   i2c_target_pkg::state_type st_r, st_nxt;
   logic [3:0] bit_r, bit_nxt;      // Bits seen in byte
   logic [7:0] shf_r, shf_nxt;      // Address shifter
   logic frame_r, frame_nxt;        // Between start and stop
   logic addressed_r, addressed_nxt; // Matched this frame
   logic [19:0] low_r, low_nxt;     // Cumulative low count
   logic [3:0] hcnt_r, hcnt_nxt;    // Hold delay count
   logic hpend_r, hpend_nxt;        // Pending data change
   logic hval_r, hval_nxt;          // Pending drive value
   logic sdaoe_r, sdaoe_nxt;        // Data line pulled low
   logic sclst_r, sclst_nxt;        // Clock hold

   // Decoded link events
   logic scl_rise, scl_fall, start_c, stop_c, tmo_c;
   logic [3:0] hold_cyc;

   // Enable runs through two stages; busy while they lag
   // [R9] delayed enable
   assign busy = (ensync_r[1] != ctrl_r.enable);
   // [R1] target mode gate
   assign active = ensync_r[1] & (ctrl_r.mode == `MODE_TARGET);

   // Bus handshake and register updates
   always_comb begin
      ack_nxt = (read | write) & ~ack_r;
      ctrl_nxt = ctrl_r;
      mask_nxt = mask_r;
      own_nxt = own_r;
      rdata_nxt = rdata_r;
      release_req = 1'b0;
      flag_nxt = flag_r;
      // First cycle of a read latches data
      if (read & ~ack_r) begin
         rdata_nxt = 32'h0000_0000;
         if (address[4]) begin
            if (address[3:0] == `OFS_OWN_ADDR) begin
               rdata_nxt[6:0] = own_r;
            end
         end else begin
            unique case (address[3:0])
               // [R9] value last written reads back
               `OFS_CONTROL_A: rdata_nxt = ctrl_r;
               // [R11] busy indication
               `OFS_STATUS: rdata_nxt = {27'h0, addressed_r, frame_r,
                                         st_r == i2c_target_pkg::ST_HOLD,
                                         ensync_r[1], busy};
               `OFS_INT_FLAG: rdata_nxt[3:0] = flag_r;
               `OFS_INT_MASK: rdata_nxt[3:0] = mask_r;
               default: rdata_nxt = 32'h0000_0000;
            endcase
         end
      end
      // Writes take effect on the answer cycle
      if (write & ack_r) begin
         if (address == {1'b0, `OFS_CONTROL_A}) begin
            // [R10] settings act at once
            ctrl_nxt = writedata & `CA_WMASK;
         end
         if (address == {1'b0, `OFS_INT_MASK}) begin
            mask_nxt = writedata[3:0];
         end
         if (address == {1'b1, `OFS_OWN_ADDR}) begin
            own_nxt = writedata[6:0];
         end
         if (address == {1'b1, `OFS_COMMAND}) begin
            release_req = writedata[0];
         end
      end
      // Read of flags clears only the bits it returned
      if (read & ack_r & (address == {1'b0, `OFS_INT_FLAG})) begin
         flag_nxt = flag_r & ~rdata_r[3:0];
      end
      // [R3] set wins, timeout clears nothing
      flag_nxt = flag_nxt | ev;
      ensync_nxt = {ensync_r[0], ctrl_r.enable};
   end

   // Register bank flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_r <= 1'b0;
         ctrl_r <= `CA_RESET;
         mask_r <= 4'h0;
         own_r <= 7'h00;
         rdata_r <= 32'h0000_0000;
         flag_r <= 4'h0;
         ensync_r <= 2'h0;
      end else begin
         ack_r <= ack_nxt;
         ctrl_r <= ctrl_nxt;
         mask_r <= mask_nxt;
         own_r <= own_nxt;
         rdata_r <= rdata_nxt;
         flag_r <= flag_nxt;
         ensync_r <= ensync_nxt;
      end
   end

   // Link sampling: level changes once stages two and three agree
   always_comb begin
      scl_sh_nxt = {scl_sh_r[1:0], scl_in};
      sda_sh_nxt = {sda_sh_r[1:0], sda_in};
      lvl_nxt = lvl_r;
      if (scl_sh_r[1] == scl_sh_r[2]) begin
         lvl_nxt.scl = scl_sh_r[2];
      end
      if (sda_sh_r[1] == sda_sh_r[2]) begin
         lvl_nxt.sda = sda_sh_r[2];
      end
      prv_nxt = lvl_r;
   end

   // Sampling flops, idle bus is high
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scl_sh_r <= 3'h7;
         sda_sh_r <= 3'h7;
         lvl_r <= 2'h3;
         prv_r <= 2'h3;
      end else begin
         scl_sh_r <= scl_sh_nxt;
         sda_sh_r <= sda_sh_nxt;
         lvl_r <= lvl_nxt;
         prv_r <= prv_nxt;
      end
   end

   assign scl_rise = lvl_r.scl & ~prv_r.scl;
   assign scl_fall = ~lvl_r.scl & prv_r.scl;
   assign start_c = lvl_r.scl & prv_r.scl & prv_r.sda & ~lvl_r.sda;
   assign stop_c = lvl_r.scl & prv_r.scl & ~prv_r.sda & lvl_r.sda;
   // [R2] cumulative low beyond limit
   assign tmo_c = ctrl_r.clock_low_ext_timeout_en & frame_r &
                  (low_r > TMO_LIMIT);

   // [R5] hold select to cycle count
   always_comb begin
      unique case (ctrl_r.data_hold_select)
         2'h0: hold_cyc = 4'h0;
         2'h1: hold_cyc = HOLD1;
         2'h2: hold_cyc = HOLD2;
         2'h3: hold_cyc = HOLD3;
      endcase
   end

   // Target engine next state
   always_comb begin
      st_nxt = st_r;
      bit_nxt = bit_r;
      shf_nxt = shf_r;
      frame_nxt = frame_r;
      addressed_nxt = addressed_r;
      low_nxt = low_r;
      hcnt_nxt = hcnt_r;
      hpend_nxt = hpend_r;
      hval_nxt = hval_r;
      sdaoe_nxt = sdaoe_r;
      sclst_nxt = sclst_r;
      ev = {busy & (ensync_nxt[1] == ctrl_r.enable), 3'h0};
      // Count low time between start and stop
      if (frame_r & ~lvl_r.scl & ~tmo_c) begin
         low_nxt = low_r + 20'h00001;
      end
      // Pending data change after hold delay
      if (hpend_r) begin
         if (hcnt_r == 4'h0) begin
            sdaoe_nxt = hval_r;
            hpend_nxt = 1'b0;
         end else begin
            hcnt_nxt = hcnt_r - 4'h1;
         end
      end
      unique case (st_r)
         i2c_target_pkg::ST_ADDR: begin
            if (scl_rise) begin
               shf_nxt = {shf_r[6:0], lvl_r.sda};
               bit_nxt = bit_r + 4'h1;
            end else if (scl_fall & (bit_r == `BITS_PER_BYTE)) begin
               // [R7] standby without run drops all
               if ((shf_r[7:1] == own_r) &
                   ~(standby_sleep & ~ctrl_r.standby_run)) begin
                  addressed_nxt = 1'b1;
                  ev[`IF_ADDR] = 1'b1;
                  hpend_nxt = 1'b1;
                  hval_nxt = 1'b1;
                  // [R5] acknowledge after hold
                  hcnt_nxt = hold_cyc;
                  st_nxt = i2c_target_pkg::ST_ACK;
               end else begin
                  st_nxt = i2c_target_pkg::ST_PASS;
               end
            end
         end
         i2c_target_pkg::ST_ACK: begin
            if (scl_fall) begin
               // Stretch clock at once, release data after hold
               hpend_nxt = 1'b1;
               hval_nxt = 1'b0;
               hcnt_nxt = hold_cyc;
               sclst_nxt = 1'b1;
               st_nxt = i2c_target_pkg::ST_HOLD;
            end
         end
         i2c_target_pkg::ST_HOLD: begin
            if (release_req) begin
               sclst_nxt = 1'b0;
               st_nxt = i2c_target_pkg::ST_PASS;
            end
         end
         i2c_target_pkg::ST_PASS: begin
            st_nxt = st_r;
         end
         default: begin
            st_nxt = i2c_target_pkg::ST_IDLE;
         end
      endcase
      // Start begins a frame, also a repeated one
      if (start_c & active) begin
         frame_nxt = 1'b1;
         low_nxt = 20'h00000;
         bit_nxt = 4'h0;
         st_nxt = i2c_target_pkg::ST_ADDR;
      end
      // Stop ends the frame
      if (stop_c) begin
         // [R4] stop flagged when addressed
         if (addressed_r) begin
            ev[`IF_STOP] = 1'b1;
         end
         frame_nxt = 1'b0;
         addressed_nxt = 1'b0;
         low_nxt = 20'h00000;
         st_nxt = i2c_target_pkg::ST_IDLE;
      end
      // [R2] timeout releases and resets engine
      if (tmo_c) begin
         ev[`IF_TMO] = 1'b1;
         sclst_nxt = 1'b0;
         sdaoe_nxt = 1'b0;
         hpend_nxt = 1'b0;
         low_nxt = 20'h00000;
         st_nxt = i2c_target_pkg::ST_IDLE;
      end
      // Disabled target lets go of the bus
      if (~active) begin
         sclst_nxt = 1'b0;
         sdaoe_nxt = 1'b0;
         hpend_nxt = 1'b0;
         frame_nxt = 1'b0;
         addressed_nxt = 1'b0;
         st_nxt = i2c_target_pkg::ST_IDLE;
      end
   end

   // Engine flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= i2c_target_pkg::ST_IDLE;
         bit_r <= 4'h0;
         shf_r <= 8'h00;
         frame_r <= 1'b0;
         addressed_r <= 1'b0;
         low_r <= 20'h00000;
         hcnt_r <= 4'h0;
         hpend_r <= 1'b0;
         hval_r <= 1'b0;
         sdaoe_r <= 1'b0;
         sclst_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         bit_r <= bit_nxt;
         shf_r <= shf_nxt;
         frame_r <= frame_nxt;
         addressed_r <= addressed_nxt;
         low_r <= low_nxt;
         hcnt_r <= hcnt_nxt;
         hpend_r <= hpend_nxt;
         hval_r <= hval_nxt;
         sdaoe_r <= sdaoe_nxt;
         sclst_r <= sclst_nxt;
      end
   end

   // Outputs
   assign waitrequest = (read | write) & ~ack_r;
   assign readdata = rdata_r;
   assign scl_out = 1'b0;
   assign scl_oe = sclst_r;
   assign sda_out = 1'b0;
   assign sda_oe = sdaoe_r;
   assign irq = |(flag_r & mask_r);
   // [R7] wake on enabled address match
   assign wake_req = standby_sleep & ctrl_r.standby_run &
                     flag_r[`IF_ADDR] & mask_r[`IF_ADDR];
   // [R6] pin usage
   assign four_wire_en = ctrl_r.pin_usage_select;
   // [R8] speed class
   assign speed_class = ctrl_r.speed_class;

endmodule : i2c_target_control

/* File: verif/i2c_target_chk.sv */
`timescale 1ns/100ps
`include "i2c_target_defs.svh"
module i2c_target_chk #(
   parameter int TIMEOUT_CYCLES = 625000
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic scl_oe,
   input wire logic standby_sleep,
   input wire logic wake_req,
   input wire logic irq,
   input wire logic four_wire_en,
   input wire logic [1:0] speed_class
);
   // Accepted control write, finished reads
   logic ctl_wr, rd_done, ctl_rd;
   // Timeout enable copy, clock hold length
   logic to_en_r, to_en_nxt;
   int hold_r, hold_nxt;
   assign ctl_wr = write && !waitrequest && address == 5'h00;
   assign rd_done = read && !waitrequest;
   assign ctl_rd = rd_done && address == 5'h00;
   // Next helper values
   always_comb begin
      to_en_nxt = ctl_wr ? writedata[23] : to_en_r;
      hold_nxt = scl_oe ? hold_r + 1 : 0;
   end
   // Helper registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         to_en_r <= 1'b0;
         hold_r <= 0;
      end else begin
         to_en_r <= to_en_nxt;
         hold_r <= hold_nxt;
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   wait_one_a: assert property ((read || write) && waitrequest
      |=> !waitrequest) else $error("bus wait too long");
   wait_first_a: assert property ((read || write)
      && !$past(read || write) |-> waitrequest) else $error("no wait");
   pin_sel_a: assert property (ctl_wr
      |=> four_wire_en == $past(writedata[16]))
      else $error("pin usage not applied");
   spd_sel_a: assert property (ctl_wr
      |=> speed_class == $past(writedata[25:24])) else $error("speed wrong");
   ctl_read_a: assert property (ctl_rd |-> readdata[16] == four_wire_en
      && readdata[25:24] == speed_class) else $error("readback wrong");
   rsv_zero_a: assert property (ctl_rd |-> (readdata & ~`CA_WMASK) == 32'h0)
      else $error("reserved bits set");
   unmap_zero_a: assert property (rd_done && (address[1:0] != 2'h0
      || address == 5'h14) |-> readdata == 32'h0) else $error("unmapped");
   wake_cause_a: assert property (wake_req |-> standby_sleep)
      else $error("wake outside standby");
   hold_bound_a: assert property (to_en_r
      |-> hold_r <= TIMEOUT_CYCLES + 8)
      else $error("clock hold too long");
   cover property ($rose(scl_oe));
   cover property ($rose(irq));
   cover property ($rose(wake_req));
endmodule : i2c_target_chk

/* File: verif/i2c_ctrl_model.sv */
`timescale 1ns/100ps
module i2c_ctrl_model (
   input wire logic scl_line,
   input wire logic sda_line,
   output logic scl_low,
   output logic sda_low
);
   // Idle: both lines released to pull-up
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // Release clock, honour any stretch
   task automatic scl_up;
      scl_low = 1'b0;
      wait (scl_line === 1'b1);
   endtask : scl_up
   // Data falls while clock high
   task automatic start;
      sda_low = 1'b0;
      scl_up();
      #160 sda_low = 1'b1;
      #160 scl_low = 1'b1;
   endtask : start
   // Eight bits msb first, ack on ninth
   task automatic put_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= -1; i--) begin
         #80 sda_low = (i >= 0) ? !b[i] : 1'b0;
         #80 scl_up();
         #160 ack = sda_line;
         scl_low = 1'b1;
      end
   endtask : put_byte
   // Data rises while clock high
   task automatic stop;
      #80 sda_low = 1'b1;
      #80 scl_up();
      #160 sda_low = 1'b0;
      // Bus free time, lets the target see the stop
      #160;
   endtask : stop
endmodule : i2c_ctrl_model

/* File: verif/i2c_target_control_config_tb_top.sv */
`timescale 1ns/100ps
module i2c_target_control_config_tb_top;
   // Design and model signals
   logic clk, sys_rst, read, write, standby_sleep, ack;
   logic [4:0] address;
   logic [31:0] writedata, readdata, q;
   logic waitrequest, scl_out, scl_oe, sda_out, sda_oe, wake_req, irq;
   logic four_wire_en, m_scl_low, m_sda_low;
   logic [1:0] speed_class;
   wire scl_w, sda_w;
   int n_errors = 0;
   int total_checks = 0;
   // Open-drain lines with pull-ups
   assign scl_w = !(m_scl_low || (scl_oe && !scl_out));
   assign sda_w = !(m_sda_low || (sda_oe && !sda_out));
   i2c_target_control #(.TIMEOUT_CYCLES(200)) dut_u (
      .clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .scl_in(scl_w), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
      .standby_sleep(standby_sleep), .wake_req(wake_req), .irq(irq),
      .four_wire_en(four_wire_en), .speed_class(speed_class));
   i2c_ctrl_model m_u (.scl_line(scl_w), .sda_line(sda_w),
      .scl_low(m_scl_low), .sda_low(m_sda_low));
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One bus cycle, waits for the answer
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      #1;
      chk(32'(n < 50), 32'h1);
   endtask : bus
   // Read and compare
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd
   // Address frame, optional clock release
   task automatic frame(input logic [6:0] a, input logic e, input logic rel);
      m_u.start();
      m_u.put_byte({a, 1'b0}, ack);
      chk(ack, e);
      if (rel) begin
         // Let the target reach its clock hold first
         repeat (12) @(posedge clk);
         chk(scl_oe, 1'b1);
         bus(1'b1, 5'h14, 32'h1);
      end
      m_u.stop();
   endtask : frame
   // Reset values, field codes, unmapped place
   task automatic t_regs;
      rd(5'h00, 32'h0);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 5'h00, {6'h0, i[1:0], 7'h0, i[0], 16'h0});
         chk(speed_class, i[1:0]);
         chk(four_wire_en, i[0]);
      end
      bus(1'b1, 5'h00, 32'hffff_ffff);
      rd(5'h00, 32'h03b1_009e);
      bus(1'b1, 5'h01, 32'hffff_ffff);
      rd(5'h01, 32'h0);
      bus(1'b1, 5'h00, 32'h0);
      $display("regs done");
   endtask : t_regs
   // Enable crossing, target mode
   task automatic t_sync;
      bus(1'b1, 5'h00, 32'h0000_0012);
      rd(5'h00, 32'h0000_0012);
      rd(5'h04, 32'h2);
      rd(5'h08, 32'h8);
      $display("sync done");
   endtask : t_sync
   // Match, mismatch, mask and flags
   task automatic t_addr;
      bus(1'b1, 5'h10, 32'h2a);
      bus(1'b1, 5'h00, 32'h0010_0012);
      frame(7'h15, 1'b1, 1'b0);
      rd(5'h08, 32'h0);
      frame(7'h2a, 1'b0, 1'b1);
      chk(irq, 1'b0);
      bus(1'b1, 5'h0c, 32'hf);
      chk(irq, 1'b1);
      rd(5'h08, 32'h3);
      chk(irq, 1'b0);
      $display("addr done");
   endtask : t_addr
   // Clock hold runs out
   task automatic t_tmo;
      int n;
      n = 0;
      bus(1'b1, 5'h00, 32'h0090_0012);
      m_u.start();
      m_u.put_byte(8'h54, ack);
      chk(ack, 1'b0);
      repeat (20) @(posedge clk);
      chk(scl_oe, 1'b1);
      while (scl_oe !== 1'b0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n < 400), 32'h1);
      rd(5'h08, 32'h5);
      m_u.stop();
      rd(5'h08, 32'h2);
      $display("timeout done");
   endtask : t_tmo
   // Standby drops or wakes
   task automatic t_stby;
      @(posedge clk) standby_sleep <= 1'b1;
      frame(7'h2a, 1'b1, 1'b0);
      chk(wake_req, 1'b0);
      bus(1'b1, 5'h00, 32'h0090_0092);
      m_u.start();
      m_u.put_byte(8'h54, ack);
      chk(ack, 1'b0);
      chk(wake_req, 1'b1);
      // Release only once the clock hold is in place
      repeat (12) @(posedge clk);
      chk(scl_oe, 1'b1);
      bus(1'b1, 5'h14, 32'h1);
      m_u.stop();
      @(posedge clk) standby_sleep <= 1'b0;
      rd(5'h08, 32'h3);
      $display("standby done");
   endtask : t_stby
   // Counts and verdict
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 5'h0;
      writedata = 32'h0;
      standby_sleep = 1'b0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_sync();
      t_addr();
      t_tmo();
      t_stby();
      end_of_test();
   end
   // Watchdog
   initial begin
      #800000;
      n_errors++;
      end_of_test();
   end
endmodule : i2c_target_control_config_tb_top
bind i2c_target_control i2c_target_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
   chk_u (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
   .write(write), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .scl_oe(scl_oe),
   .standby_sleep(standby_sleep), .wake_req(wake_req), .irq(irq),
   .four_wire_en(four_wire_en), .speed_class(speed_class));
